// ### shared/conv_host_defines.svh
`ifndef CONV_HOST_DEFINES_SVH
`define CONV_HOST_DEFINES_SVH

// clock period in ns
`define CLK_PERIOD_NS      100
// least convert strobe low time, ns
`define WR_LOW_MIN_NS      600
// longest convert strobe low time, ns
`define WR_LOW_MAX_NS      50000
// least gap from convert rise to read strobe, ns
`define RD_AFTER_WR_NS     600
// typical internal timeout to done flag, ns
`define DONE_TIMEOUT_NS    800
// read-only mode conversion limit: two 800 ns phases, ns
`define RD_MODE_CONV_NS    1600
// least recovery gap between conversions, ns
`define RECOVERY_NS        500

// least times round up, longest times round down
`define WR_LOW_CYC   ((`WR_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_MAX_CYC   (`WR_LOW_MAX_NS / `CLK_PERIOD_NS)
`define RD_GAP_CYC   ((`RD_AFTER_WR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DONE_CYC     ((`DONE_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RDM_CYC      ((`RD_MODE_CONV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOV_CYC    ((`RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// reset value of the captured result
`define RESULT_RST   8'h00

`endif

// ### shared/conv_host_pkg.sv
package conv_host_pkg;
   typedef logic [7:0] result_t;
   typedef enum logic [1:0] {
      RD_ONLY,
      WR_RD_WAIT_DONE,
      WR_RD_FAST
   } seq_mode_e;
endpackage

// ### hw/conv_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "conv_host_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// [R1] converter adds an overrange comparator; host captures its flag
// [R2] converter banks alternate zero and compare phases
// [R3] write mode: convert strobe fall starts upper-half compare
// [R4] host holds convert strobe low at least 600 ns
// [R5] host drops read strobe at least 600 ns after convert rises
// [R6] read strobe fall re-phases banks for next conversion
// [R7] host drives static mode strap: low read-only, high write-then-read
// [R8] read-only: host holds read low until done flag falls
// [R9] read-only: ready output shows converter busy
// [R10] read-only phases timed internally, 800 ns each
// [R11] interrupt style host waits for done flag before reading
// [R12] fast host reads 600 ns after convert rises, no wait
// [R13] early read makes done flag fall at once with data
// [R14] stand-alone: select and read low, convert pulse starts it
// [R15] host keeps convert strobe low no longer than 50 us
// [R16] host waits at least 500 ns before next conversion
// [R17] input sampled while convert low, or first 800 ns of read
// [R18] all-zero code equals negative reference level
// [R19] read-only completion: ready released, done flag low
// [R20] read-only: read fall with select low starts conversion
// [R21] overrange output always driven
// [R22] result bus driven only while select and read low; the model always drives it, inverted unless done is also low
// [R23] done flag returns high on read release or new start
module conv_host #(
   parameter int WR_CYC   = `WR_LOW_CYC,
   parameter int RD_CYC   = `RD_GAP_CYC,
   parameter int RECV_CYC = `RECOV_CYC,
   parameter int TMO_CYC  = `RDM_CYC + `DONE_CYC
) (
   input  wire logic                   REF_CLK,
   input  wire logic                   RST,
   input  wire logic                   START,
   input  wire conv_host_pkg::seq_mode_e MODE_SEL,
   output var  logic                   BUSY,
   output var  logic                   DONE,
   output var  logic                   TIMEOUT,
   output var  conv_host_pkg::result_t RESULT,
   output var  logic                   OVERRANGE,
   output var  logic                   CS_N,
   output var  logic                   WR_N,
   output var  logic                   RD_N,
   output var  logic                   MODE,
   input  wire logic                   INT_N,
   input  wire logic                   RDY_OE,
   input  wire conv_host_pkg::result_t RESULT_BUS,
   input  wire logic                   OFL_N
);
   import conv_host_pkg::*;

   // counter is 16 bits and the strobe must stay under its ceiling
   if (WR_CYC < 1 || WR_CYC > `WR_MAX_CYC || RD_CYC < 1
       || RECV_CYC < 1 || TMO_CYC < 1 || TMO_CYC > 65535) begin : g_bad_cfg
      $error("conv_host: timing parameter out of range");
   end

   typedef enum logic [2:0] {
      IDLE, WR_LOW, WR_GAP, RD_LOW, RECOVER
   } state_e;

   state_e      state;
   logic [15:0] cnt;
   seq_mode_e   cur_mode;
   logic        cnt_done;

   assign cnt_done = (cnt == 16'h0000);

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state    <= IDLE;
         cnt      <= 16'h0000;
         cur_mode <= RD_ONLY;
      end else begin
         if (!cnt_done)
            cnt <= cnt - 16'h0001;
         case (state)
            IDLE: begin
               if (START) begin
                  cur_mode <= MODE_SEL;
                  if (MODE_SEL == RD_ONLY) begin
                     state <= RD_LOW;                        // R20
                     cnt   <= 16'(TMO_CYC);
                  end else begin
                     state <= WR_LOW;                        // R3
                     cnt   <= 16'(WR_CYC - 1);               // R4
                  end
               end
            end
            WR_LOW: begin
               // ending on the count keeps low under 50 us
               if (cnt_done) begin                           // R15
                  state <= WR_GAP;
                  cnt   <= (cur_mode == WR_RD_FAST)
                           ? 16'(RD_CYC - 1) : 16'(TMO_CYC);
               end
            end
            WR_GAP: begin
               if (cur_mode == WR_RD_FAST) begin
                  if (cnt_done) begin                       // R5 R12
                     state <= RD_LOW;
                     cnt   <= 16'(TMO_CYC);
                  end
               end else if (!INT_N || cnt_done) begin      // R11
                  state <= RD_LOW;
                  cnt   <= 16'(TMO_CYC);
               end
            end
            RD_LOW: begin
               // read held until done falls; counter guards a dead part
               if (!INT_N || cnt_done) begin                 // R8 R13
                  state <= RECOVER;
                  cnt   <= 16'(RECV_CYC - 1);
               end
            end
            RECOVER: begin
               if (cnt_done)                                 // R16
                  state <= IDLE;
            end
            default: state <= IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pins, all registered
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         CS_N <= 1'b1;
         WR_N <= 1'b1;
         RD_N <= 1'b1;
         MODE <= 1'b0;
      end else begin
         // strap follows selection only while idle, so it stays static
         if (state == IDLE && START)
            MODE <= (MODE_SEL != RD_ONLY);                   // R7
         CS_N <= !((state == IDLE && START) || state == WR_LOW
                   || state == WR_GAP
                   || (state == RD_LOW && INT_N && !cnt_done));
         WR_N <= !((state == IDLE && START && MODE_SEL != RD_ONLY)
                   || (state == WR_LOW && !cnt_done));      // R3 R4
         RD_N <= !((state == IDLE && START && MODE_SEL == RD_ONLY)
                   || (state == WR_GAP && cur_mode == WR_RD_FAST
                       && cnt_done)
                   || (state == WR_GAP && cur_mode != WR_RD_FAST
                       && (!INT_N || cnt_done))
                   || (state == RD_LOW && INT_N && !cnt_done)); // R22
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // result capture and status
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RESULT    <= `RESULT_RST;
         OVERRANGE <= 1'b0;
         DONE      <= 1'b0;
         TIMEOUT   <= 1'b0;
         BUSY      <= 1'b0;
      end else begin
         DONE <= 1'b0;
         BUSY <= !(state == IDLE && !START)
                 && !(state == RECOVER && cnt_done);
         // overrange pin is always driven, so sample it every cycle
         OVERRANGE <= !OFL_N;                                // R1 R21
         if (state == IDLE && START)
            TIMEOUT <= 1'b0;
         if (state == RD_LOW) begin
            if (!INT_N) begin                                // R19
               RESULT <= RESULT_BUS;                         // R18
               DONE   <= 1'b1;
            end else if (cnt_done)
               TIMEOUT <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   localparam int WR_MAX_LIM = `WR_MAX_CYC;

   property p_wr_low_min;
      @(posedge REF_CLK) disable iff (RST)
      $fell(WR_N) |-> !WR_N [*6];
   endproperty
   a_wr_low_min: assert property (p_wr_low_min) // R4
      else $error("convert strobe low too briefly");
   property p_wr_low_max;
      @(posedge REF_CLK) disable iff (RST)
      $fell(WR_N) |-> ##[1:WR_MAX_LIM] WR_N;
   endproperty
   a_wr_low_max: assert property (p_wr_low_max); // R15
   property p_ovr_follow;
      @(posedge REF_CLK) disable iff (RST)
      1'b1 |=> (OVERRANGE == !$past(OFL_N));
   endproperty
   a_ovr_follow: assert property (p_ovr_follow); // R21

   property p_rd_gap;
      @(posedge REF_CLK) disable iff (RST)
      ($rose(WR_N) && MODE) |-> RD_N [*6];
   endproperty
   a_rd_gap: assert property (p_rd_gap); // R5
   sequence s_recover;
      (CS_N && RD_N && WR_N) [*5];
   endsequence
   property p_recover;
      @(posedge REF_CLK) disable iff (RST)
      $rose(RD_N) |-> s_recover;
   endproperty
   a_recover: assert property (p_recover); // R16
   property p_no_overlap;
      @(posedge REF_CLK) disable iff (RST) !(!WR_N && !RD_N);
   endproperty
   a_no_overlap: assert property (p_no_overlap); // R22
   property p_done_release;
      @(posedge REF_CLK) disable iff (RST)
      (state == RD_LOW && !INT_N) |=> (RD_N && CS_N);
   endproperty
   a_done_release: assert property (p_done_release); // R8
   property p_mode_static;
      @(posedge REF_CLK) disable iff (RST)
      // strap moves with the select edge itself, then must hold
      (!CS_N && !$past(CS_N)) |-> $stable(MODE);
   endproperty
   a_mode_static: assert property (p_mode_static); // R7
   property p_rdonly_start;
      @(posedge REF_CLK) disable iff (RST)
      ($fell(RD_N) && !MODE) |-> !CS_N && WR_N;
   endproperty
   a_rdonly_start: assert property (p_rdonly_start); // R20
   property p_capture;
      @(posedge REF_CLK) disable iff (RST)
      (state == RD_LOW && !INT_N) |=> DONE && RESULT == $past(RESULT_BUS);
   endproperty
   a_capture: assert property (p_capture); // R13
endmodule
`default_nettype wire

// ### sim/conv_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module conv_dev_model (
   input  wire logic       clk,
   input  wire logic       CS_N,
   input  wire logic       WR_N,
   input  wire logic       RD_N,
   input  wire logic       MODE,
   input  wire logic [8:0] vin,
   input  wire logic       mute,
   output var  logic       INT_N,
   output wire logic       RDY_OE,
   output wire logic [7:0] RESULT_BUS,
   output wire logic       OFL_N
);
   logic [8:0] held = 9'h000;
   logic       wr_q = 1'b1;
   logic       rd_q = 1'b1;
   int         cnt = 0;
   wire logic [7:0] code = held[8] ? 8'hFF : held[7:0];
   initial INT_N = 1'b1;
   ////////////////////////////////////////////////////////////////////////
   // clock stands in for analog timeouts: 8 ticks are 800 ns
   always @(posedge clk) begin
      wr_q <= WR_N;
      rd_q <= RD_N | CS_N;
      if (cnt > 1) cnt <= cnt - 1;
      if (cnt == 1) begin
         cnt <= 0;
         INT_N <= mute;
      end
      if (!MODE && !CS_N && !RD_N && rd_q) begin
         held <= vin;
         cnt <= 16;
      end
      if (MODE && !WR_N) begin
         held <= vin;
         INT_N <= 1'b1;
      end
      if (MODE && WR_N && !wr_q) cnt <= 8;
      if (MODE && !CS_N && !RD_N && rd_q && cnt > 1) cnt <= 1;
      if ((RD_N | CS_N) && !rd_q) INT_N <= 1'b1;
   end
   assign RDY_OE = !MODE && cnt > 0;
   // released bus shows the inverse so a stale capture is caught
   assign RESULT_BUS = (!CS_N && !RD_N && !INT_N) ? code : ~code;
   assign OFL_N = !held[8];
endmodule
`default_nettype wire

// ### sim/half_flash_adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "conv_host_defines.svh"
module half_flash_adc_conversion_sequencer_tb;
   import conv_host_pkg::*;
   localparam logic [8:0] EDGE_V [3] = '{9'h000, 9'h0FF, 9'h100};
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       start = 1'b0;
   seq_mode_e  mode_sel = RD_ONLY;
   logic       busy, done, timeout, overrange, cs_n, wr_n, rd_n, mode;
   logic       int_n, rdy_oe, ofl_n;
   logic       mute = 1'b0;
   result_t    result, bus;
   logic [8:0] vin = 9'h000;
   logic       wr_p = 1'b1;
   logic       rd_p = 1'b1;
   int         bad_count = 0, n_tests = 0, cyc = 0, seed = 52540;
   int         wr_run = 0, gap = 0, rest = 100;
   result_t    exp_q [$];

   always #50 ref_clk = ~ref_clk;

   conv_host dut (.REF_CLK(ref_clk), .RST(rst), .START(start),
      .MODE_SEL(mode_sel), .BUSY(busy), .DONE(done), .TIMEOUT(timeout),
      .RESULT(result), .OVERRANGE(overrange), .CS_N(cs_n), .WR_N(wr_n),
      .RD_N(rd_n), .MODE(mode), .INT_N(int_n), .RDY_OE(rdy_oe),
      .RESULT_BUS(bus), .OFL_N(ofl_n));
   conv_dev_model dev (.clk(ref_clk), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n),
      .MODE(mode), .vin(vin), .mute(mute), .INT_N(int_n), .RDY_OE(rdy_oe),
      .RESULT_BUS(bus), .OFL_N(ofl_n));

   task automatic check(input logic [8:0] seen, input logic [8:0] want);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // strobe timing watched on the falling edge, opposite the launching edge
   always @(negedge ref_clk) begin
      cyc++;
      if (cyc > 3000) begin
         bad_count++;
         close_out();
      end
      if (wr_n === 1'b0) wr_run++;
      gap++;
      rest++;
      if (wr_n === 1'b1 && wr_p === 1'b0) begin
         check(9'(wr_run >= `WR_LOW_CYC && wr_run <= `WR_MAX_CYC), 9'h001);
         wr_run = 0;
         gap = 1;
      end
      if (rd_n === 1'b0 && rd_p === 1'b1) begin
         check(9'(cs_n), 9'h000);
         if (mode === 1'b1) check(9'(gap > `RD_GAP_CYC), 9'h001);
      end
      if ((rd_n === 1'b0 && rd_p === 1'b1 && mode === 1'b0) ||
          (wr_n === 1'b0 && wr_p === 1'b1))
         check(9'(rest > `RECOV_CYC), 9'h001);
      if (rd_n === 1'b1 && rd_p === 1'b0) rest = 0;
      wr_p = wr_n;
      rd_p = rd_n;
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [8:0] v;
      result_t    last;
      seq_mode_e  m;
      int         k;
      last = 8'h00;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      // boundary codes first, then random ones; last three get no done flag
      for (int i = 0; i < 12; i++) begin
         m = seq_mode_e'(i % 3);
         v = 9'($random(seed));
         if (i < 3) v = EDGE_V[i];
         if (i < 9) exp_q.push_back(v[8] ? 8'hFF : v[7:0]);
         @(posedge ref_clk);
         start <= 1'b1;
         mode_sel <= m;
         vin <= v;
         mute <= (i >= 9);
         @(posedge ref_clk);
         start <= 1'b0;
         k = 0;
         do begin
            @(negedge ref_clk);
            k++;
         end while (done !== 1'b1 && timeout !== 1'b1 && k < 60);
         check(9'(k < 60), 9'h001);
         if (i < 9) last = exp_q.pop_front();
         check(9'(result), 9'(last));
         check(9'(timeout), 9'(i >= 9));
         check(9'(overrange), 9'(v[8]));
         check(9'(mode), 9'(m != RD_ONLY));
         k = 0;
         while (busy !== 1'b0 && k < 20) begin
            @(negedge ref_clk);
            k++;
         end
         check(9'(busy), 9'h000);
      end
      close_out();
   end
endmodule
`default_nettype wire
